// file: inc/sfp_pkg.sv
// shared constants and types for the status flag and privilege check block
package sfp_pkg;
	// primary opcodes reserved for coprocessor extension instructions
	localparam logic [7:0] EXT_OP0 = 8'h0E;
	localparam logic [7:0] EXT_OP1 = 8'h0F;
	localparam logic [7:0] EXT_OP2 = 8'h4E;
	localparam logic [7:0] EXT_OP3 = 8'h4F;
	localparam logic [7:0] EXT_OP4 = 8'h8E;
	localparam logic [7:0] EXT_OP5 = 8'h8F;
	localparam int EXT_OP_COUNT = 6;
	// bit positions inside the flag byte
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_PV = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;
	// coprocessor enable position inside the control byte
	localparam int CTRL_EXT_EN = 2;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] FLAG_MASK = 8'hFC;
	localparam logic [7:0] CTRL_MASK = 8'hFF;

	typedef enum logic [2:0] {
		AM_REG = 3'b000,
		AM_IND = 3'b001,
		AM_DIRECT = 3'b010,
		AM_INDEX = 3'b011,
		AM_IMM = 3'b100,
		AM_OTHER = 3'b101
	} sfp_amode_t;

	typedef enum logic [1:0] {
		XC_INTERNAL = 2'b00,
		XC_MEMORY = 2'b01,
		XC_REGISTER = 2'b10,
		XC_FLAGS = 2'b11
	} sfp_xclass_t;

	// what an instruction does to the flags
	typedef enum logic [3:0] {
		FOP_NONE = 4'b0000,
		FOP_ARITH = 4'b0001,
		FOP_LOGIC = 4'b0010,
		FOP_BLOCK = 4'b0011,
		FOP_COMPARE_BLK = 4'b0100,
		FOP_SET = 4'b0101,
		FOP_CLEAR = 4'b0110,
		FOP_INVERT = 4'b0111,
		FOP_BYTE_LOAD = 4'b1000,
		FOP_WORD_LOAD = 4'b1001,
		FOP_XFLAGS = 4'b1010,
		FOP_ROTATE = 4'b1011
	} sfp_fop_t;

	typedef enum logic [4:0] {
		PI_NONE = 5'b00000,
		PI_IO = 5'b00001,
		PI_SPECIAL_IO = 5'b00010,
		PI_INT_MASK = 5'b00011,
		PI_INT_UNMASK = 5'b00100,
		PI_HALT = 5'b00101,
		PI_INT_RETURN = 5'b00110,
		PI_CTRL_LOAD = 5'b00111,
		PI_STATUS_LOAD = 5'b01000,
		PI_MP_BIT_TEST = 5'b01001,
		PI_MP_REQUEST = 5'b01010,
		PI_MP_RESET = 5'b01011,
		PI_MP_SET = 5'b01100,
		PI_FLAG_OP = 5'b01101,
		PI_NOP = 5'b01110
	} sfp_pclass_t;

	// one instruction as presented by the decoder
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		sfp_amode_t amode;
		sfp_xclass_t xclass;
		sfp_pclass_t pclass;
		sfp_fop_t fop;
		logic byteOp;
		logic isSub;
		logic [3:0] cond;
		logic isCond;
	} sfp_instr_t;

	// result side information from the execution unit
	typedef struct packed {
		logic [15:0] result;
		logic [15:0] opA;
		logic [15:0] opB;
		logic carryOut;
		logic carry3;
		logic counterZero;
		logic compareMet;
		logic [7:0] loadFlags;
		logic [7:0] loadCtrl;
		logic [3:0] flagSel;
	} sfp_exec_t;

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] ctrl;
	} sfp_state_t;
endpackage

// file: src/sfp_cond_eval.sv
// condition code evaluator for conditional instructions
`timescale 1ns/100ps
`default_nettype none
module sfp_cond_eval (
	input wire logic [3:0] cond,
	input wire logic [7:0] flags,
	output logic condTrue
);
	logic c;
	logic z;
	logic s;
	logic v;
	assign c = flags[sfp_pkg::FLAG_C];
	assign z = flags[sfp_pkg::FLAG_Z];
	assign s = flags[sfp_pkg::FLAG_S];
	assign v = flags[sfp_pkg::FLAG_PV];
	// only c, z, s and p/v are looked at; d and h never enter a test
	always_comb begin
		case (cond)
			4'h0: condTrue = 1'b0;
			4'h1: condTrue = s ^ v;
			4'h2: condTrue = z | (s ^ v);
			4'h3: condTrue = c | z;
			4'h4: condTrue = v;
			4'h5: condTrue = s;
			4'h6: condTrue = z;
			4'h7: condTrue = c;
			4'h8: condTrue = 1'b1;
			4'h9: condTrue = ~(s ^ v);
			4'hA: condTrue = ~(z | (s ^ v));
			4'hB: condTrue = ~(c | z);
			4'hC: condTrue = ~v;
			4'hD: condTrue = ~s;
			4'hE: condTrue = ~z;
			default: condTrue = ~c;
		endcase
	end
endmodule
`default_nettype wire

// file: src/sfp_ext_dispatch.sv
// extension opcode recognition and coprocessor or trap dispatch
`timescale 1ns/100ps
`default_nettype none
module sfp_ext_dispatch (
	input wire logic valid,
	input wire logic [7:0] opcode,
	input wire sfp_pkg::sfp_amode_t amode,
	input wire logic extEnable,
	output logic isExt,
	output logic toCoproc,
	output logic extTrap,
	output logic amodeBad
);
	localparam logic [7:0] OPS [sfp_pkg::EXT_OP_COUNT] = '{sfp_pkg::EXT_OP0, sfp_pkg::EXT_OP1,
		sfp_pkg::EXT_OP2, sfp_pkg::EXT_OP3, sfp_pkg::EXT_OP4, sfp_pkg::EXT_OP5};
	logic [sfp_pkg::EXT_OP_COUNT-1:0] hit;
	genvar i;
	generate
		for (i = 0; i < sfp_pkg::EXT_OP_COUNT; i++) begin : g_match
			assign hit[i] = (opcode == OPS[i]);
		end
	endgenerate
	logic modeOk;
	assign modeOk = (amode == sfp_pkg::AM_REG) || (amode == sfp_pkg::AM_IND) ||
		(amode == sfp_pkg::AM_DIRECT) || (amode == sfp_pkg::AM_INDEX);
	assign isExt = valid & (|hit);
	assign amodeBad = isExt & ~modeOk;
	assign toCoproc = isExt & modeOk & extEnable;
	assign extTrap = isExt & modeOk & ~extEnable;
endmodule
`default_nettype wire

// file: src/sfp_status_flags.sv
// flag and control word, flag updates, privilege and extension checks
`timescale 1ns/100ps
`default_nettype none
module sfp_status_flags (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire sfp_pkg::sfp_instr_t instr,
	input wire sfp_pkg::sfp_exec_t exec,
	input wire logic systemMode,
	output logic execute,
	output logic condTrue,
	output logic toCoproc,
	output sfp_pkg::sfp_xclass_t coprocClass,
	output logic extTrap,
	output logic privTrap,
	output logic amodeBad,
	output logic carryIn,
	output logic [7:0] flagsOut,
	output logic [7:0] ctrlOut,
	output logic coprocessorEnableBit
);
	sfp_pkg::sfp_state_t state_q;
	sfp_pkg::sfp_state_t state_d;
	logic isExt;
	logic isPriv;
	logic condOk;
	logic accept;
	logic [7:0] selMask;
	logic [3:0] sel;
	logic msb;
	logic signA;
	logic signB;
	logic ovf;
	logic zeroRes;
	logic parityEven;

	sfp_cond_eval u_cond (
		.cond(instr.cond),
		.flags(state_q.flags),
		.condTrue(condTrue)
	);

	sfp_ext_dispatch u_ext (
		.valid(instr.valid),
		.opcode(instr.opcode),
		.amode(instr.amode),
		.extEnable(state_q.ctrl[sfp_pkg::CTRL_EXT_EN]),
		.isExt(isExt),
		.toCoproc(toCoproc),
		.extTrap(extTrap),
		.amodeBad(amodeBad)
	);

	// flag op and nop are the only control-group ops open to normal mode
	always_comb begin
		case (instr.pclass)
			sfp_pkg::PI_IO, sfp_pkg::PI_SPECIAL_IO, sfp_pkg::PI_INT_MASK,
			sfp_pkg::PI_INT_UNMASK, sfp_pkg::PI_HALT, sfp_pkg::PI_INT_RETURN,
			sfp_pkg::PI_CTRL_LOAD, sfp_pkg::PI_STATUS_LOAD, sfp_pkg::PI_MP_BIT_TEST,
			sfp_pkg::PI_MP_REQUEST, sfp_pkg::PI_MP_RESET, sfp_pkg::PI_MP_SET: isPriv = 1'b1;
			default: isPriv = 1'b0;
		endcase
	end

	assign privTrap = instr.valid & isPriv & ~systemMode;
	assign condOk = ~instr.isCond | condTrue;
	assign accept = instr.valid & ~privTrap & ~extTrap & ~amodeBad & ~isExt & condOk;
	assign execute = accept;
	assign coprocClass = instr.xclass;
	assign carryIn = state_q.flags[sfp_pkg::FLAG_C];
	assign flagsOut = state_q.flags;
	assign ctrlOut = state_q.ctrl;
	assign coprocessorEnableBit = state_q.ctrl[sfp_pkg::CTRL_EXT_EN];

	assign sel = exec.flagSel;
	assign selMask = {sel[3], sel[2], sel[1], sel[0], 4'h0};
	assign msb = instr.byteOp ? exec.result[7] : exec.result[15];
	assign signA = instr.byteOp ? exec.opA[7] : exec.opA[15];
	assign signB = instr.byteOp ? exec.opB[7] : exec.opB[15];
	// subtraction overflows when operand signs differ and result sign follows b
	assign ovf = instr.isSub ? ((signA ^ signB) & (msb ^ signA)) : (~(signA ^ signB) & (msb ^ signA));
	assign zeroRes = instr.byteOp ? (exec.result[7:0] == 8'h00) : (exec.result == 16'h0000);
	assign parityEven = ~(^exec.result[7:0]);

	always_comb begin
		state_d = state_q;
		if (accept) begin
			case (instr.fop)
				sfp_pkg::FOP_ARITH: begin
					state_d.flags[sfp_pkg::FLAG_C] = exec.carryOut;
					state_d.flags[sfp_pkg::FLAG_Z] = zeroRes;
					state_d.flags[sfp_pkg::FLAG_S] = msb;
					state_d.flags[sfp_pkg::FLAG_PV] = ovf;
					if (instr.byteOp) begin
						state_d.flags[sfp_pkg::FLAG_D] = instr.isSub;
						state_d.flags[sfp_pkg::FLAG_H] = exec.carry3;
					end
				end
				sfp_pkg::FOP_LOGIC: begin
					state_d.flags[sfp_pkg::FLAG_Z] = zeroRes;
					state_d.flags[sfp_pkg::FLAG_S] = msb;
					if (instr.byteOp) begin
						state_d.flags[sfp_pkg::FLAG_PV] = parityEven;
					end
				end
				sfp_pkg::FOP_ROTATE: begin
					state_d.flags[sfp_pkg::FLAG_C] = exec.carryOut;
					state_d.flags[sfp_pkg::FLAG_Z] = zeroRes;
					state_d.flags[sfp_pkg::FLAG_S] = msb;
				end
				sfp_pkg::FOP_BLOCK: begin
					state_d.flags[sfp_pkg::FLAG_PV] = exec.counterZero;
				end
				sfp_pkg::FOP_COMPARE_BLK: begin
					// c and s also follow the compare; d and h stay
					state_d.flags[sfp_pkg::FLAG_C] = exec.carryOut;
					state_d.flags[sfp_pkg::FLAG_S] = msb;
					state_d.flags[sfp_pkg::FLAG_Z] = exec.compareMet;
					state_d.flags[sfp_pkg::FLAG_PV] = exec.counterZero;
				end
				sfp_pkg::FOP_SET: begin
					state_d.flags = state_q.flags | selMask;
				end
				sfp_pkg::FOP_CLEAR: begin
					state_d.flags = state_q.flags & ~selMask;
				end
				sfp_pkg::FOP_INVERT: begin
					state_d.flags = state_q.flags ^ selMask;
				end
				sfp_pkg::FOP_BYTE_LOAD: begin
					// c z s pv only: d, h and the control byte stay, so no mode check is needed
					state_d.flags = (state_q.flags & 8'h0F) | (exec.loadFlags & 8'hF0);
				end
				sfp_pkg::FOP_WORD_LOAD: begin
					// the class decode traps it in normal mode; the guard covers a mis-decoded class
					if (systemMode) begin
						state_d.flags = exec.loadFlags & sfp_pkg::FLAG_MASK;
						state_d.ctrl = exec.loadCtrl & sfp_pkg::CTRL_MASK;
					end
				end
				sfp_pkg::FOP_XFLAGS: begin
					// coprocessor flags land in c z s pv only
					state_d.flags = (state_q.flags & 8'h0F) | (exec.loadFlags & 8'hF0);
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
		if (instr.valid & isExt & toCoproc & (instr.xclass == sfp_pkg::XC_FLAGS)) begin
			state_d.flags = (state_q.flags & 8'h0F) | (exec.loadFlags & 8'hF0);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= '{flags: sfp_pkg::FLAGS_RESET, ctrl: sfp_pkg::CTRL_RESET};
		end else begin
			state_q <= state_d;
		end
	end
endmodule
`default_nettype wire

// file: testbench/sfp_coproc_model.sv
// coprocessor model: hands its flag register back on a flag transfer
`timescale 1ns/100ps
`default_nettype none
module sfp_coproc_model (
	input wire logic toCoproc,
	input wire sfp_pkg::sfp_xclass_t coprocClass,
	input wire logic [7:0] presetFlags,
	output logic [7:0] coprocFlags
);
	// unaddressed it drives the inverse, so a stale value cannot pass
	assign coprocFlags = toCoproc && coprocClass == sfp_pkg::XC_FLAGS ? presetFlags : ~presetFlags;
endmodule
`default_nettype wire

// file: testbench/sfp_status_flags_monitor.sv
// port checker for the status flag and privilege block
`timescale 1ns/100ps
`default_nettype none
module sfp_status_flags_monitor (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire sfp_pkg::sfp_instr_t instr,
	input wire sfp_pkg::sfp_exec_t exec,
	input wire logic systemMode,
	input wire logic execute,
	input wire logic condTrue,
	input wire logic toCoproc,
	input wire logic extTrap,
	input wire logic privTrap,
	input wire logic amodeBad,
	input wire logic [7:0] flagsOut,
	input wire logic [7:0] ctrlOut,
	input wire logic coprocessorEnableBit
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	logic isPriv;
	logic isExt;
	assign isPriv = instr.pclass inside {[sfp_pkg::PI_IO:sfp_pkg::PI_MP_SET]};
	assign isExt = instr.opcode[3:1] == 3'h7 && instr.opcode[7:4] inside {4'h0, 4'h4, 4'h8};
	sequence setTaken;
		instr.valid && execute && instr.fop == sfp_pkg::FOP_SET;
	endsequence
	sequence byteLoadTaken;
		instr.valid && execute && instr.fop == sfp_pkg::FOP_BYTE_LOAD;
	endsequence
	priv_trap_a: assert property (instr.valid |-> privTrap == (isPriv && !systemMode))
		else $error("privilege trap wrong");
	ext_only_a: assert property (toCoproc || extTrap |-> isExt && !execute)
		else $error("extension outside reserved set");
	ext_route_a: assert property (instr.valid && isExt && !amodeBad && !privTrap |->
		toCoproc == coprocessorEnableBit && extTrap != coprocessorEnableBit) else $error("extension routing wrong");
	amode_bad_a: assert property (instr.valid && isExt |-> amodeBad == (instr.amode > sfp_pkg::AM_INDEX))
		else $error("addressing check wrong");
	trap_hold_a: assert property (instr.valid && (privTrap || extTrap) |=> $stable(flagsOut) && $stable(ctrlOut))
		else $error("trap changed state");
	set_op_a: assert property (setTaken |=> flagsOut == ($past(flagsOut) | {$past(exec.flagSel), 4'h0}))
		else $error("flag set wrong");
	byte_load_a: assert property (byteLoadTaken |=> $stable(ctrlOut) &&
		flagsOut == {$past(exec.loadFlags[7:4]), $past(flagsOut[3:0])}) else $error("byte load wrong");
	cond_gate_a: assert property (instr.valid && instr.isCond && !condTrue |-> !execute)
		else $error("false condition executed");
	ctrl_guard_a: assert property (instr.valid && !systemMode |=> $stable(ctrlOut))
		else $error("control byte written in normal mode");
	dh_keep_a: assert property (instr.valid && execute && instr.fop inside {sfp_pkg::FOP_SET, sfp_pkg::FOP_CLEAR,
		sfp_pkg::FOP_INVERT, sfp_pkg::FOP_BYTE_LOAD} |=> $stable(flagsOut[3:2])) else $error("d or h changed by flag op");
endmodule
bind sfp_status_flags sfp_status_flags_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst), .instr(instr),
	.exec(exec), .systemMode(systemMode), .execute(execute), .condTrue(condTrue), .toCoproc(toCoproc),
	.extTrap(extTrap), .privTrap(privTrap), .amodeBad(amodeBad), .flagsOut(flagsOut), .ctrlOut(ctrlOut),
	.coprocessorEnableBit(coprocessorEnableBit));
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the status flag and privilege block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic systemMode = 1'b1;
	logic useCop = 1'b0;
	sfp_pkg::sfp_instr_t instr = '0;
	sfp_pkg::sfp_instr_t n = '0;
	sfp_pkg::sfp_exec_t exc = '0;
	sfp_pkg::sfp_exec_t nx = '0;
	sfp_pkg::sfp_exec_t exDut;
	sfp_pkg::sfp_xclass_t cls;
	logic execute, condTrue, toCoproc, extTrap, privTrap, amodeBad, carryIn, enBit;
	logic [7:0] flagsOut, ctrlOut, copFlags, e, b;
	int mismatches = 0;
	int n_compared = 0;
	always #50 core_clk = ~core_clk;
	always_comb begin
		exDut = exc;
		if (useCop)
			exDut.loadFlags = copFlags;
	end
	sfp_status_flags i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .instr(instr), .exec(exDut),
		.systemMode(systemMode), .execute(execute), .condTrue(condTrue), .toCoproc(toCoproc), .coprocClass(cls),
		.extTrap(extTrap), .privTrap(privTrap), .amodeBad(amodeBad), .carryIn(carryIn), .flagsOut(flagsOut),
		.ctrlOut(ctrlOut), .coprocessorEnableBit(enBit));
	sfp_coproc_model i_cop (.toCoproc(toCoproc), .coprocClass(cls), .presetFlags(8'hA0), .coprocFlags(copFlags));
	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// inputs only ever change at the falling edge
	task automatic put;
		@(negedge core_clk);
		instr = n;
		exc = nx;
		#1;
	endtask
	// one instruction taken at exactly one rising edge, then the flags compared
	task automatic run(input sfp_pkg::sfp_fop_t f, input logic [7:0] m, input logic [7:0] x);
		n.fop = f;
		put;
		@(negedge core_clk);
		instr.valid = 1'b0;
		n.fop = sfp_pkg::FOP_NONE;
		chk("flags", flagsOut & m, x);
	endtask
	task automatic ar(input logic sb, input logic [15:0] r, input logic [15:0] a, input logic [15:0] c,
		input logic co, input logic c3, input logic [7:0] x);
		n.isSub = sb;
		nx.result = r;
		nx.opA = a;
		nx.opB = c;
		nx.carryOut = co;
		nx.carry3 = c3;
		run(sfp_pkg::FOP_ARITH, 8'hFF, x);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		chk("reset", flagsOut | ctrlOut, 8'h00);
		sys_rst = 1'b0;
		n.valid = 1'b1;
		for (int en = 0; en < 2; en++) begin
			n.pclass = sfp_pkg::PI_CTRL_LOAD;
			nx.loadFlags = 8'hFF;
			nx.loadCtrl = 8'(en * 4);
			run(sfp_pkg::FOP_WORD_LOAD, 8'hFF, 8'hFC);
			chk("enable", enBit, 8'(en));
			n.pclass = sfp_pkg::PI_NONE;
			for (int o = 0; o < 256; o++) begin
				n.opcode = 8'(o);
				put;
				e = {7'h00, o[3:1] == 3'h7 && o[7:4] inside {4'h0, 4'h4, 4'h8}};
				chk("copro", toCoproc, e & 8'(en));
				chk("xtrap", extTrap, e & 8'(1 - en));
				chk("xexec", execute, ~e & 8'h01);
			end
		end
		n.opcode = 8'h8F;
		for (int am = 0; am < 6; am++) begin
			n.amode = sfp_pkg::sfp_amode_t'(am);
			put;
			chk("amode", amodeBad, 8'(am > 3));
			chk("acop", toCoproc | extTrap, 8'(am < 4));
		end
		n.amode = sfp_pkg::AM_REG;
		n.opcode = 8'h0E;
		n.xclass = sfp_pkg::XC_FLAGS;
		useCop = 1'b1;
		run(sfp_pkg::FOP_XFLAGS, 8'hFF, 8'hAC);
		chk("class", cls, 8'h03);
		useCop = 1'b0;
		n.opcode = 8'h00;
		$display("extension tests done");
		systemMode = 1'b0;
		for (int p = 0; p < 15; p++) begin
			n.pclass = sfp_pkg::sfp_pclass_t'(p);
			put;
			chk("ptrap", privTrap, 8'(p > 0 && p < 13));
		end
		n.pclass = sfp_pkg::PI_CTRL_LOAD;
		nx.loadFlags = 8'h00;
		nx.loadCtrl = 8'h00;
		run(sfp_pkg::FOP_WORD_LOAD, 8'hFF, 8'hAC);
		n.pclass = sfp_pkg::PI_FLAG_OP;
		nx.loadFlags = 8'h50;
		run(sfp_pkg::FOP_BYTE_LOAD, 8'hFF, 8'h5C);
		chk("ctrl", ctrlOut, 8'h04);
		// a word load outside the privileged class must still leave both bytes alone
		run(sfp_pkg::FOP_WORD_LOAD, 8'hFF, 8'h5C);
		chk("ctrlkeep", ctrlOut, 8'h04);
		nx.flagSel = 4'hA;
		run(sfp_pkg::FOP_SET, 8'hFF, 8'hFC);
		nx.flagSel = 4'h5;
		run(sfp_pkg::FOP_CLEAR, 8'hFF, 8'hAC);
		nx.flagSel = 4'hF;
		run(sfp_pkg::FOP_INVERT, 8'hFF, 8'h5C);
		// tests in code order 7..0: C, Z, S, PV, ULE, LE, LT, never; the upper half inverts
		b = {flagsOut[7:4], flagsOut[7] | flagsOut[6], (flagsOut[5] ^ flagsOut[4]) | flagsOut[6],
			flagsOut[5] ^ flagsOut[4], 1'b0};
		n.isCond = 1'b1;
		for (int c = 0; c < 16; c++) begin
			n.cond = 4'(c);
			put;
			chk("cond", condTrue, 8'(b[c % 8] ^ (c > 7)));
			chk("cexec", execute, 8'(b[c % 8] ^ (c > 7)));
		end
		n.cond = 4'h0;
		run(sfp_pkg::FOP_INVERT, 8'hFF, 8'h5C);
		n.isCond = 1'b0;
		$display("privilege and flag tests done");
		n.pclass = sfp_pkg::PI_NONE;
		n.byteOp = 1'b1;
		ar(1'b0, 16'h0021, 16'h00E1, 16'h0040, 1'b1, 1'b0, 8'h80);
		chk("carry", carryIn, 8'h01);
		ar(1'b0, 16'h0080, 16'h007F, 16'h0001, 1'b0, 1'b1, 8'h34);
		ar(1'b1, 16'h00FF, 16'h0000, 16'h0001, 1'b1, 1'b1, 8'hAC);
		n.byteOp = 1'b0;
		// word arithmetic leaves d and h as the byte subtract left them
		ar(1'b0, 16'h8000, 16'h7FFF, 16'h0001, 1'b0, 1'b1, 8'h3C);
		n.byteOp = 1'b1;
		nx.result = 16'h0000;
		run(sfp_pkg::FOP_LOGIC, 8'h70, 8'h50);
		nx.result = 16'h0080;
		run(sfp_pkg::FOP_LOGIC, 8'h70, 8'h20);
		nx.counterZero = 1'b1;
		run(sfp_pkg::FOP_BLOCK, 8'h10, 8'h10);
		nx.compareMet = 1'b1;
		run(sfp_pkg::FOP_COMPARE_BLK, 8'h40, 8'h40);
		nx.result = 16'h0000;
		nx.carryOut = 1'b1;
		run(sfp_pkg::FOP_ROTATE, 8'hE0, 8'hC0);
		chk("rcarry", carryIn, 8'h01);
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("rerun", flagsOut | ctrlOut, 8'h00);
		sys_rst = 1'b0;
		$display("result flag tests done");
		final_report;
	end
	initial begin
		repeat (3000) @(posedge core_clk);
		mismatches++;
		final_report;
	end
endmodule
`default_nettype wire
